/* File: hw/mnalu_core.v */
// multiply, negate, left-justify, complement, OR and no-operation datapath
// Notes on behaviour
// - prefixed two-operand signed word product: dest word times source into long
// - prefixed three-operand signed word product of two words into long
// - prefixed two-operand signed byte product into word destination
// - prefixed three-operand signed byte product into word destination
// - unprefixed two-operand unsigned word product into double word
// - unprefixed three-operand unsigned word product into double word
// - unprefixed two-operand unsigned byte product into word
// - unprefixed three-operand unsigned byte product into word
// - multiplies leave sticky undefined, all other flags unchanged
// - word negate writes two's complement, updates Z N C V, keeps sticky
// - byte negate writes two's complement, updates Z N C V, keeps sticky
// - no-operation changes no register or flag
// - left-justify long until top bit set, at most 31 shifts, count to byte
// - left-justify failing sets Z, clears C, keeps V VT sticky
// - word invert updates Z N, clears C V, keeps VT and sticky
// - byte invert updates Z N, clears C V, keeps VT and sticky
// - word OR updates Z N, clears C V, keeps VT and sticky
// - byte OR updates Z N, clears C V, keeps VT and sticky
`timescale 1ns/1ps
`include "mnalu_map.vh"
module mnalu_core (
  input  wire        i_clk_sys,
  input  wire        i_srst,
  input  wire        i_ce,
  input  wire        i_start,
  input  wire        i_prefix,
  input  wire [7:0]  i_opcode,
  input  wire [15:0] i_src_a,
  input  wire [15:0] i_src_b,
  input  wire [31:0] i_long,
  input  wire [5:0]  i_flags,
  output reg  [31:0] o_result,
  output reg  [7:0]  o_count,
  output reg  [5:0]  o_flags,
  output reg  [1:0]  o_addr_mode,
  output reg         o_wr_word,
  output reg         o_wr_byte,
  output reg         o_wr_long,
  output reg         o_wr_count,
  output reg         o_illegal,
  output reg         o_done,
  output reg         o_busy
);
  localparam ST_IDLE = 2'b00;
  localparam ST_JUST = 2'b01;

  ////////////////////////////////////////////////////////////////////////
  reg  [1:0]  state_reg;
  reg  [1:0]  state_next;
  reg  [31:0] just_val_reg;
  reg  [4:0]  just_cnt_reg;
  reg  [5:0]  just_flags_reg;
  wire [31:0] step_val;
  wire [4:0]  step_cnt;
  wire        step_done;
  wire [5:0]  op_hi;
  wire        is_mode_op;
  reg  [31:0] res;
  reg  [5:0]  flg;
  reg         wr_w;
  reg         wr_b;
  reg         wr_l;
  reg         ill;
  reg         go_just;
  reg  [16:0] neg_w;
  reg  [8:0]  neg_b;
  reg  signed [15:0] sprod_b;

  assign op_hi = i_opcode[7:2];
  assign is_mode_op = (op_hi == `MNALU_OP_WPROD2) | (op_hi == `MNALU_OP_WPROD3) |
                      (op_hi == `MNALU_OP_BPROD2) | (op_hi == `MNALU_OP_BPROD3) |
                      (op_hi == `MNALU_OP_WOR) | (op_hi == `MNALU_OP_BOR);

  mnalu_shift_step #(
    .WIDTH(32)
  ) u_step (
    .i_value(just_val_reg),
    .i_count(just_cnt_reg),
    .i_limit(`MNALU_LJUST_MAX),
    .o_value(step_val),
    .o_count(step_cnt),
    .o_done (step_done)
  );

  ////////////////////////////////////////////////////////////////////////
  always @* begin
    res     = 32'h00000000;
    flg     = i_flags;
    wr_w    = 1'b0;
    wr_b    = 1'b0;
    wr_l    = 1'b0;
    ill     = 1'b0;
    go_just = 1'b0;
    neg_w   = 17'h00000 - {1'b0, i_src_a};
    neg_b   = 9'h000 - {1'b0, i_src_a[7:0]};
    // both factors sign-extended to the 16-bit product width
    sprod_b = $signed(i_src_a[7:0]) * $signed(i_src_b[7:0]);
    if (i_prefix) begin
      // sticky cleared here, a legal choice for an undefined flag
      flg[`MNALU_FLAG_ST] = 1'b0;
      case (op_hi)
        `MNALU_OP_WPROD2,
        `MNALU_OP_WPROD3: begin
          res  = $signed(i_src_a) * $signed(i_src_b);
          wr_l = 1'b1;
        end
        `MNALU_OP_BPROD2,
        `MNALU_OP_BPROD3: begin
          res  = {16'h0000, sprod_b};
          wr_w = 1'b1;
        end
        default: begin
          flg = i_flags;
          ill = 1'b1;
        end
      endcase
    end else begin
      case (i_opcode)
        `MNALU_OP_WNEG: begin
          res[15:0] = neg_w[15:0];
          wr_w = 1'b1;
          flg[`MNALU_FLAG_Z] = (neg_w[15:0] == 16'h0000);
          flg[`MNALU_FLAG_N] = neg_w[15];
          flg[`MNALU_FLAG_C] = neg_w[16];
          flg[`MNALU_FLAG_V] = (i_src_a == 16'h8000);
          flg[`MNALU_FLAG_VT] = i_flags[`MNALU_FLAG_VT] | (i_src_a == 16'h8000);
        end
        `MNALU_OP_BNEG: begin
          res[7:0] = neg_b[7:0];
          wr_b = 1'b1;
          flg[`MNALU_FLAG_Z] = (neg_b[7:0] == 8'h00);
          flg[`MNALU_FLAG_N] = neg_b[7];
          flg[`MNALU_FLAG_C] = neg_b[8];
          flg[`MNALU_FLAG_V] = (i_src_a[7:0] == 8'h80);
          flg[`MNALU_FLAG_VT] = i_flags[`MNALU_FLAG_VT] | (i_src_a[7:0] == 8'h80);
        end
        `MNALU_OP_NOP: begin
          res = 32'h00000000;
        end
        `MNALU_OP_LJUST: begin
          go_just = 1'b1;
        end
        `MNALU_OP_WINV: begin
          res[15:0] = ~i_src_a;
          wr_w = 1'b1;
          flg[`MNALU_FLAG_Z] = (i_src_a == 16'hFFFF);
          flg[`MNALU_FLAG_N] = ~i_src_a[15];
          flg[`MNALU_FLAG_C] = 1'b0;
          flg[`MNALU_FLAG_V] = 1'b0;
        end
        `MNALU_OP_BINV: begin
          res[7:0] = ~i_src_a[7:0];
          wr_b = 1'b1;
          flg[`MNALU_FLAG_Z] = (i_src_a[7:0] == 8'hFF);
          flg[`MNALU_FLAG_N] = ~i_src_a[7];
          flg[`MNALU_FLAG_C] = 1'b0;
          flg[`MNALU_FLAG_V] = 1'b0;
        end
        default: begin
          case (op_hi)
            `MNALU_OP_WPROD2,
            `MNALU_OP_WPROD3: begin
              res  = i_src_a * i_src_b;
              wr_l = 1'b1;
              flg[`MNALU_FLAG_ST] = 1'b0;
            end
            `MNALU_OP_BPROD2,
            `MNALU_OP_BPROD3: begin
              res[15:0] = i_src_a[7:0] * i_src_b[7:0];
              wr_w = 1'b1;
              flg[`MNALU_FLAG_ST] = 1'b0;
            end
            `MNALU_OP_WOR: begin
              res[15:0] = i_src_a | i_src_b;
              wr_w = 1'b1;
              flg[`MNALU_FLAG_Z] = ((i_src_a | i_src_b) == 16'h0000);
              flg[`MNALU_FLAG_N] = i_src_a[15] | i_src_b[15];
              flg[`MNALU_FLAG_C] = 1'b0;
              flg[`MNALU_FLAG_V] = 1'b0;
            end
            `MNALU_OP_BOR: begin
              res[7:0] = i_src_a[7:0] | i_src_b[7:0];
              wr_b = 1'b1;
              flg[`MNALU_FLAG_Z] = ((i_src_a[7:0] | i_src_b[7:0]) == 8'h00);
              flg[`MNALU_FLAG_N] = i_src_a[7] | i_src_b[7];
              flg[`MNALU_FLAG_C] = 1'b0;
              flg[`MNALU_FLAG_V] = 1'b0;
            end
            default: begin
              ill = 1'b1;
            end
          endcase
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (i_start && go_just) begin
          state_next = ST_JUST;
        end
      end
      ST_JUST: begin
        if (step_done) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always @(posedge i_clk_sys) begin
    if (i_srst) begin
      state_reg      <= ST_IDLE;
      just_val_reg   <= 32'h00000000;
      just_cnt_reg   <= 5'h00;
      just_flags_reg <= `MNALU_FLAGS_RESET;
      o_result       <= 32'h00000000;
      o_count        <= 8'h00;
      o_flags        <= `MNALU_FLAGS_RESET;
      o_addr_mode    <= 2'h0;
      o_wr_word      <= 1'b0;
      o_wr_byte      <= 1'b0;
      o_wr_long      <= 1'b0;
      o_wr_count     <= 1'b0;
      o_illegal      <= 1'b0;
      o_done         <= 1'b0;
      o_busy         <= 1'b0;
    end else if (i_ce) begin
      state_reg  <= state_next;
      o_wr_word  <= 1'b0;
      o_wr_byte  <= 1'b0;
      o_wr_long  <= 1'b0;
      o_wr_count <= 1'b0;
      o_illegal  <= 1'b0;
      o_done     <= 1'b0;
      if (state_reg == ST_IDLE && i_start) begin
        // hand the mode back to the fetch logic
        o_addr_mode <= is_mode_op ? i_opcode[1:0] : 2'h0;
        if (go_just) begin
          just_val_reg   <= i_long;
          just_cnt_reg   <= 5'h00;
          just_flags_reg <= i_flags;
          o_busy         <= 1'b1;
        end else begin
          o_result  <= res;
          o_flags   <= flg;
          o_wr_word <= wr_w;
          o_wr_byte <= wr_b;
          o_wr_long <= wr_l;
          o_illegal <= ill;
          o_done    <= 1'b1;
        end
      end else if (state_reg == ST_JUST) begin
        just_val_reg <= step_val;
        just_cnt_reg <= step_cnt;
        if (step_done) begin
          o_result   <= just_val_reg;
          o_count    <= {3'h0, just_cnt_reg};
          o_wr_long  <= 1'b1;
          o_wr_count <= 1'b1;
          o_done     <= 1'b1;
          o_busy     <= 1'b0;
          // zero set only when top bit never came up; negative left as top bit
          o_flags <= {~just_val_reg[31], just_val_reg[31], 1'b0,
                      just_flags_reg[`MNALU_FLAG_V], just_flags_reg[`MNALU_FLAG_VT],
                      just_flags_reg[`MNALU_FLAG_ST]};
        end
      end
    end
  end
endmodule

/* File: hw/mnalu_map.vh */
// opcode encodings, flag positions and timing for the multiply/negate/logic datapath
`ifndef MNALU_MAP_VH
`define MNALU_MAP_VH
`define MNALU_OP_PREFIX     8'hFE
`define MNALU_OP_WPROD2     6'h1B
`define MNALU_OP_WPROD3     6'h13
`define MNALU_OP_BPROD2     6'h1F
`define MNALU_OP_BPROD3     6'h17
`define MNALU_OP_WNEG       8'h03
`define MNALU_OP_BNEG       8'h13
`define MNALU_OP_NOP        8'hFD
`define MNALU_OP_LJUST      8'h0F
`define MNALU_OP_WINV       8'h02
`define MNALU_OP_BINV       8'h12
`define MNALU_OP_WOR        6'h20
`define MNALU_OP_BOR        6'h24
`define MNALU_FLAG_Z        5
`define MNALU_FLAG_N        4
`define MNALU_FLAG_C        3
`define MNALU_FLAG_V        2
`define MNALU_FLAG_VT       1
`define MNALU_FLAG_ST       0
`define MNALU_FLAGS_RESET   6'h00
`define MNALU_LJUST_MAX     5'h1F
`endif

/* File: hw/mnalu_shift_step.v */
// one left-justify step: shift left while the top bit is clear and the count is below its limit
`timescale 1ns/1ps
module mnalu_shift_step #(
  parameter WIDTH = 32
) (
  input  wire [WIDTH-1:0] i_value,
  input  wire [4:0]       i_count,
  input  wire [4:0]       i_limit,
  output wire [WIDTH-1:0] o_value,
  output wire [4:0]       o_count,
  output wire             o_done
);
  assign o_done  = i_value[WIDTH-1] | (i_count >= i_limit);
  assign o_value = o_done ? i_value : {i_value[WIDTH-2:0], 1'b0};
  assign o_count = o_done ? i_count : i_count + 5'h01;
endmodule

/* File: test/mnalu_core_chk.sv */
// timing and flag checks on the datapath ports
`timescale 1ns/1ps
`include "mnalu_map.vh"
module mnalu_core_chk (
  input wire        i_clk_sys,
  input wire        i_srst,
  input wire        i_ce,
  input wire        i_start,
  input wire        i_prefix,
  input wire [7:0]  i_opcode,
  input wire [5:0]  i_flags,
  input wire [31:0] o_result,
  input wire [7:0]  o_count,
  input wire [5:0]  o_flags,
  input wire        o_wr_word,
  input wire        o_wr_byte,
  input wire        o_wr_long,
  input wire        o_wr_count,
  input wire        o_illegal,
  input wire        o_done,
  input wire        o_busy
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_srst);
  wire tk = i_ce & i_start & ~o_busy;
  wire mul = (i_opcode[7:2] == `MNALU_OP_WPROD2) || (i_opcode[7:2] == `MNALU_OP_WPROD3) ||
             (i_opcode[7:2] == `MNALU_OP_BPROD2) || (i_opcode[7:2] == `MNALU_OP_BPROD3);
  // unprefixed codes only: a prefix in front of them is answered as illegal
  wire lj = ~i_prefix & (i_opcode == `MNALU_OP_LJUST);
  wire lg = ~i_prefix & ((i_opcode == `MNALU_OP_WINV) || (i_opcode == `MNALU_OP_BINV) ||
            (i_opcode[7:2] == `MNALU_OP_WOR) || (i_opcode[7:2] == `MNALU_OP_BOR));
  wire ng = ~i_prefix & ((i_opcode == `MNALU_OP_WNEG) || (i_opcode == `MNALU_OP_BNEG));
  // shifting edges seen while busy; frozen with the clock enable, so a stall cannot trip the bound
  reg  [5:0] busy_cnt;
  always @(posedge i_clk_sys) begin
    if (i_srst || !o_busy) begin
      busy_cnt <= 6'h00;
    end else if (i_ce) begin
      busy_cnt <= busy_cnt + 6'h01;
    end
  end
  AST_SINGLE: assert property (tk && !lj |=> o_done) else $error("single-cycle op not answered");
  AST_LJ_BUSY: assert property (tk && lj |=> o_busy && !o_done) else $error("justify not busy");
  AST_LJ_BOUND: assert property (o_busy |-> busy_cnt <= 6'h1F) else $error("justify too long");
  AST_LJ_OUT: assert property (o_done && o_wr_count |-> !o_busy && o_count <= 8'h1F && !o_flags[3] &&
    (o_result[31] != o_flags[5])) else $error("justify result bad");
  AST_ILLEGAL: assert property (o_illegal |-> o_done &&
    !(o_wr_word || o_wr_byte || o_wr_long || o_wr_count)) else $error("illegal op wrote");
  AST_MUL_KEEP: assert property (tk && mul |=> o_flags[5:1] == $past(i_flags[5:1]) && o_done)
    else $error("multiply changed flags");
  AST_NOP: assert property (tk && i_opcode == `MNALU_OP_NOP |=> o_flags == $past(i_flags) &&
    !o_wr_word && !o_wr_byte && !o_wr_long) else $error("no-op changed state");
  AST_LOGIC: assert property (tk && lg |=> o_flags[3:0] == {2'b00, $past(i_flags[1:0])})
    else $error("logic flags bad");
  AST_NEG_TRAP: assert property (tk && ng |=>
    o_flags[1] == ($past(i_flags[1]) | o_flags[2]) && o_flags[0] == $past(i_flags[0]))
    else $error("negate trap bad");
  cover property (tk && lj);
  cover property (o_illegal);
  cover property (o_done && o_flags[2]);
  cover property (tk && i_prefix && mul);
endmodule
bind mnalu_core mnalu_core_chk u_chk (.*);

/* File: test/mnalu_regfile_model.sv */
// flag register of the sequencer side, feeding current flags back to the datapath
`timescale 1ns/1ps
module mnalu_regfile_model (
  input  wire       i_clk_sys,
  input  wire       i_srst,
  input  wire       i_load,
  input  wire [5:0] i_load_flags,
  input  wire       i_done,
  input  wire       i_illegal,
  input  wire [5:0] i_new_flags,
  output reg  [5:0] o_flags
);
  // a preset from the bench wins so every op starts from known flags
  always @(posedge i_clk_sys) begin
    if (i_srst)
      o_flags <= 6'h00;
    else if (i_load)
      o_flags <= i_load_flags;
    else if (i_done && !i_illegal)
      o_flags <= i_new_flags;
  end
endmodule

/* File: test/multiply_negate_logic_alu_tb_top.sv */
// self-checking bench for the multiply/negate/logic datapath
`timescale 1ns/1ps
module multiply_negate_logic_alu_tb_top;
  reg         clk = 0, srst = 1, ce = 1, start = 0, pre = 0, ld = 0;
  reg  [7:0]  opc = 8'h00;
  reg  [15:0] a = 16'h0000, b = 16'h0000;
  reg  [31:0] lng = 32'h00000000, seed = 32'h0001666A;
  reg  [5:0]  ldf = 6'h00;
  wire [5:0]  flg, o_flags;
  wire [31:0] o_result;
  wire [7:0]  o_count;
  wire [1:0]  o_mode;
  wire        o_ww, o_wb, o_wl, o_wc, o_ill, o_done, o_busy;
  integer     err_total = 0, n_tests = 0, r, k, n, xa, ya, w;
  reg  [31:0] er, em;
  reg  [5:0]  ef;
  reg  [4:0]  ewr;
  reg  [7:0]  tbl [0:16];
  reg  [1:0]  emode;
  mnalu_core u_dut (.i_clk_sys(clk), .i_srst(srst), .i_ce(ce), .i_start(start), .i_prefix(pre),
    .i_opcode(opc), .i_src_a(a), .i_src_b(b), .i_long(lng), .i_flags(flg), .o_result(o_result),
    .o_count(o_count), .o_flags(o_flags), .o_addr_mode(o_mode), .o_wr_word(o_ww), .o_wr_byte(o_wb),
    .o_wr_long(o_wl), .o_wr_count(o_wc), .o_illegal(o_ill), .o_done(o_done), .o_busy(o_busy));
  mnalu_regfile_model u_rf (.i_clk_sys(clk), .i_srst(srst), .i_load(ld), .i_load_flags(ldf),
    .i_done(o_done), .i_illegal(o_ill), .i_new_flags(o_flags), .o_flags(flg));
  initial begin
    forever #20 clk = ~clk;
  end
  function [31:0] xs(input [31:0] s);
    reg [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  task cmp(input [127:0] nm, input [31:0] e, input [31:0] g);
    begin
      n_tests = n_tests + 1;
      if (e !== g) begin
        err_total = err_total + 1;
        $display("mismatch %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task end_of_test;
    begin
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  // reference model: result, flags, strobes {word,byte,long,count,illegal} and mode
  task model(input p, input [7:0] op, input [15:0] x, input [15:0] y, input [31:0] l, input [5:0] f);
    begin
      ef = f; er = 0; ewr = 5'b00000; emode = 2'b00; em = 32'h0000FFFF; w = op[4] ? 8 : 16;
      if (op[7:2] == 6'h1B || op[7:2] == 6'h13 || op[7:2] == 6'h1F || op[7:2] == 6'h17) begin
        xa = x & ((1 << w) - 1); ya = y & ((1 << w) - 1);
        if (p && xa >= (1 << (w - 1))) xa = xa - (1 << w);
        if (p && ya >= (1 << (w - 1))) ya = ya - (1 << w);
        er = xa * ya; em = (w == 8) ? 32'h0000FFFF : 32'hFFFFFFFF;
        ef[0] = 1'b0; ewr = (w == 8) ? 5'b10000 : 5'b00100; emode = op[1:0];
      end else if (op == 8'h0F) begin
        er = l; n = 0;
        while (!er[31] && n < 31) begin er = er << 1; n = n + 1; end
        em = 32'hFFFFFFFF; ef[5:3] = {~er[31], er[31], 1'b0}; ewr = 5'b00110;
      end else if (op == 8'hFD) begin
        ewr = 5'b00000;
      end else if (op == 8'h03 || op == 8'h13 || op == 8'h02 || op == 8'h12 || op[7:2] == 6'h20 || op[7:2] == 6'h24) begin
        em = (w == 8) ? 32'h000000FF : 32'h0000FFFF;
        er = (op[1:0] == 2'b11 && op[7] == 1'b0) ? -x : (op[7] ? x | y : ~x);
        er = er & em;
        ef[5:2] = {er == 0, er[w-1], 2'b00};
        if (op[1:0] == 2'b11 && !op[7]) begin
          ef[3] = (x & em) != 0;
          ef[2] = (x & em) == (32'h1 << (w - 1));
          ef[1] = f[1] | ef[2];
        end
        ewr = (w == 8) ? 5'b01000 : 5'b10000;
        if (op[7]) emode = op[1:0];
      end else
        ewr = 5'b00001;
    end
  endtask
  initial begin
    tbl[0] = 8'h6C; tbl[1] = 8'h4C; tbl[2] = 8'h7C; tbl[3] = 8'h5C; tbl[4] = 8'h6C; tbl[5] = 8'h4C;
    tbl[6] = 8'h7C; tbl[7] = 8'h5C; tbl[8] = 8'h03; tbl[9] = 8'h13; tbl[10] = 8'hFD; tbl[11] = 8'h0F;
    tbl[12] = 8'h02; tbl[13] = 8'h12; tbl[14] = 8'h80; tbl[15] = 8'h90; tbl[16] = 8'h00;
    repeat (20) @(posedge clk);
    srst <= 0;
    for (r = 0; r < 6; r = r + 1) begin
      for (k = 0; k < 17; k = k + 1) begin
        seed = xs(seed);
        @(posedge clk);
        ld <= 1; ldf <= seed[5:0];
        @(posedge clk);
        ld <= 0; start <= 1; pre <= k < 4; b <= seed[31:16];
        opc <= tbl[k] | ((tbl[k][7] || tbl[k][6]) && tbl[k] != 8'hFD ? seed[7:6] : 2'b00);
        a <= (r == 0) ? 16'h0000 : (r == 1) ? 16'h8000 : (r == 2) ? 16'h0080 : xs(seed);
        lng <= (r == 0) ? 32'h0 : (r == 1) ? 32'h1 : (r == 2) ? 32'h80000000 : xs(seed) >> seed[4:0];
        @(posedge clk);
        start <= 0;
        // stall a justify for three edges: nothing may advance while the enable is low
        if (opc == 8'h0F && r > 1) begin
          ce <= 0;
          repeat (3) @(posedge clk);
          ce <= 1;
          #1;
          cmp("frozen", 32'h00000001, {31'h0, o_busy & ~o_done});
        end
        #1;
        n = 0;
        while (o_done !== 1'b1 && n < 40) begin @(posedge clk); #1; n = n + 1; end
        cmp("done", 32'h00000001, {31'h0, o_done});
        model(pre, opc, a, b, lng, ldf);
        cmp("result", er & em, o_result & em);
        cmp("flags", ef, o_flags);
        cmp("strobes", ewr, {o_ww, o_wb, o_wl, o_wc, o_ill});
        cmp("mode", emode, o_mode);
        if (opc == 8'h0F) cmp("count", n, o_count);
      end
      $display("round %0d done", r);
    end
    end_of_test;
  end
  initial begin
    #800000;
    err_total = err_total + 1;
    end_of_test;
  end
endmodule
